/* hdl/codec_ctrl_pkg.sv */
// shared constants for the codec control register block
package codec_ctrl_pkg;
    // clock and timing
    localparam int REF_CLK_KHZ = 125000;
    localparam int DEBOUNCE_MS = 50;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * REF_CLK_KHZ; // longest time, exact cycle count
    localparam int NCO_TICK_KHZ = 512;
    localparam int NCO_DIV = REF_CLK_KHZ / NCO_TICK_KHZ;
    localparam int NCO_ACC_W = 17;
    // register indexes on the control port
    localparam int REG_W = 8;
    localparam int NUM_REGS = 10;
    localparam int IDX_PCM_CFG = 1;
    localparam int IDX_RX_DATA = 2;
    localparam int IDX_TX_DATA = 3;
    localparam int IDX_PATH = 4;
    localparam int IDX_TX_GAIN = 5;
    localparam int IDX_RX_GAIN = 6;
    localparam int IDX_TONE = 7;
    localparam int IDX_FREQ_ONE = 8;
    localparam int IDX_FREQ_TWO = 9;
    localparam int IDX_REMOTE = 10;
    localparam logic [7:0] REG_RESET = 8'h00;
    // pcm_interface_config fields
    localparam int TM_HI_BIT = 7;
    localparam int TM_LO_BIT = 6;
    localparam int LATCH_BIT = 5;
    localparam int RX_OVR_BIT = 4;
    localparam int TX_OVR_BIT = 3;
    localparam int VOICE_EN_BIT = 2;
    localparam int BCHAN_BIT = 1;
    localparam int CLKSRC_BIT = 0;
    // audio_path_select fields
    localparam int MIC_A_BIT = 7;
    localparam int MIC_B_BIT = 6;
    localparam int SIDETONE_BIT = 5;
    localparam int EAR_ON_BIT = 4;
    localparam int EXTRA_ON_BIT = 3;
    localparam int RING_ROUTE_BIT = 2;
    localparam int HPF_BIT = 1;
    localparam int SPEECH_BIT = 0;
    localparam logic [1:0] MIC_MUTE = 2'h0;
    // tone_gen_control and remote_key_control fields
    localparam int TONE_F1_BIT = 3;
    localparam int TONE_F2_BIT = 2;
    localparam int TONE_WAVE_BIT = 1;
    localparam int TONE_TX_BIT = 0;
    localparam int REM_EN_BIT = 7;
    localparam int REM_LATCH_BIT = 6;
    localparam int REM_INV_BIT = 5;
    localparam int REM_FLAG_BIT = 4;
    localparam logic [7:0] TONE_HIGH_CODE = 8'hA0;
    localparam logic [7:0] TONE_LOW_CODE = 8'h20;
    typedef enum logic [1:0] {
        RANGE_STD = 2'b00,
        RANGE_HALF = 2'b01,
        RANGE_DOUBLE = 2'b10,
        RANGE_BAD = 2'b11
    } tone_range_t;
    // pcm frame positions
    localparam logic [5:0] SLOT_B1 = 6'd0;
    localparam logic [5:0] SLOT_B2 = 6'd8;
    localparam logic [5:0] SLOT_LEN = 6'd8;
    localparam logic [5:0] POS_END = 6'd32;
    localparam logic [5:0] POS_PRE = 6'h3F;
    // control port framing
    localparam logic [4:0] HDR_LAST = 5'd7;
    localparam logic [4:0] DATA_FIRST = 5'd8;
    localparam logic [4:0] DATA_LAST = 5'd15;
    localparam logic [4:0] CNT_STOP = 5'd16;
    // synchroniser idle: key released, select high
    localparam logic [6:0] SYNC_IDLE = 7'h42;
endpackage

/* hdl/tone_nco.sv */
// phase accumulator tone source with three frequency ranges
`timescale 1ns/1ps
module tone_nco
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic enable,
    input wire logic [7:0] step,
    input wire codec_ctrl_pkg::tone_range_t range,
    output logic wave
);
    import codec_ctrl_pkg::*;

    logic [NCO_ACC_W-1:0] acc;

    // accumulate the step on each 512 kHz tick
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            acc <= '0;
        else if (!enable)
            acc <= '0;
        else if (tick)
            acc <= acc + NCO_ACC_W'(step);
    end

    // bit choice sets period 0.128, 0.256 or 0.064 s over the step
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            wave <= 1'b0;
        else
        begin
            case (range)
                RANGE_STD: wave <= enable & acc[NCO_ACC_W-2];
                RANGE_HALF: wave <= enable & acc[NCO_ACC_W-1];
                RANGE_DOUBLE: wave <= enable & acc[NCO_ACC_W-3];
                default: wave <= 1'b0;
            endcase
        end
    end
endmodule

/* hdl/codec_audio_control_regs.sv */
// control registers, pcm slot logic and remote key detect of the voice codec
`timescale 1ns/1ps
// Function
// - timing bit 7 low gives delayed timing; high picks normal or reverse
// - latch pin shows the inverse of its control bit
// - receive override decodes the written receive byte each frame
// - receive data register captures the incoming slot byte each frame while receive override is clear
// - transmit override sends the transmit data register every frame
// - pcm words move most significant bit first
// - voice disable stops decoding and floats the transmit slot
// - bit 1 picks first or second b channel slot
// - bit 0 picks master or auxiliary clock source
// - overrides, channel pick and data registers act only in companded mode
// - sidetone forced off while transmit path is muted
// - transmit gain nibble steps 1.5 dB up to 22.5 dB
// - earpiece nibble attenuates 2 dB steps down to -30 dB
// - extra amplifier nibble attenuates 2 dB steps down to -30 dB
// - standard range frequency is value over 0.128
// - halved range frequency is value over 0.256
// - doubled range frequency is value over 0.064
// - tone control bit 0 puts tone on the transmit data path
// - remote key bit 7 enables detection, off at reset
// - key output transparent or latched, debounced at most 50 ms
// - detect flag set after debounce of a low key, host clears
module codec_audio_control_regs
#(
    parameter int DEBOUNCE_CYCLES = codec_ctrl_pkg::DEBOUNCE_CYC
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ctrl_clk,
    input wire logic ctrl_sel_n,
    input wire logic ctrl_in,
    output logic ctrl_out,
    output logic ctrl_oe,
    input wire logic pcm_clk,
    input wire logic pcm_sync,
    input wire logic pcm_rx_in,
    output logic pcm_tx_out,
    output logic pcm_tx_oe,
    input wire logic companded_mode,
    input wire logic [codec_ctrl_pkg::REG_W-1:0] tx_path_data,
    output logic [codec_ctrl_pkg::REG_W-1:0] rx_path_data,
    output logic rx_path_valid,
    input wire logic remote_key_n,
    output logic key_detect_out,
    output logic latch_pin,
    output logic clock_source_pick,
    output logic mic_select_a,
    output logic mic_select_b,
    output logic sidetone_on,
    output logic [3:0] sidetone_atten,
    output logic [3:0] tx_gain,
    output logic earpiece_drive_on,
    output logic extra_amp_drive_on,
    output logic ring_gen_route,
    output logic rx_highpass_cut,
    output logic rx_speech_route,
    output logic [3:0] ear_atten,
    output logic [3:0] extra_atten,
    output logic [3:0] ring_atten,
    output logic low_tone_gen_on,
    output logic high_tone_gen_on,
    output logic waveform_pick,
    output logic gen_to_tx_path,
    output logic tone_one,
    output logic tone_two
);
    import codec_ctrl_pkg::*;

    localparam int DEB_W = $clog2(DEBOUNCE_CYCLES + 1);

    logic [6:0] sync_a, sync_b, sync_q;
    logic cclk_rise, cclk_fall, bclk_rise, bclk_fall, fs_last, frame_start;
    logic [4:0] sc_cnt;
    logic [7:0] sc_sh, rd_val, host_wdata;
    logic [3:0] sc_addr;
    logic sc_rd, host_wr, addr_ok, commit, rx_pend;
    logic [7:0] cfg_stage [1:NUM_REGS];
    logic [7:0] cfg_act [1:NUM_REGS];
    logic [7:0] pcm_cfg, tx_byte, rx_sh, tone_byte;
    logic delayed, reverse, pcm_active, launch, sample, rx_done;
    logic [5:0] bit_pos, next_pos, slot_start, cur_idx, nxt_idx, launch_idx;
    logic [$clog2(NCO_DIV+1)-1:0] tick_cnt;
    logic nco_tick, key_stable, key_flag, key_set, deb_done;
    logic [DEB_W-1:0] deb_cnt;

    // two-flop synchronisers on every pin input, plus a history stage
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_a <= SYNC_IDLE;
            sync_b <= SYNC_IDLE;
            sync_q <= SYNC_IDLE;
        end
        else
        begin
            sync_a <= {remote_key_n, pcm_rx_in, pcm_sync, pcm_clk, ctrl_in, ctrl_sel_n, ctrl_clk};
            sync_b <= sync_a;
            sync_q <= sync_b;
        end
    end

    // edges of the control and pcm clocks
    assign cclk_rise = sync_b[0] & ~sync_q[0];
    assign cclk_fall = ~sync_b[0] & sync_q[0];
    assign bclk_rise = sync_b[3] & ~sync_q[3];
    assign bclk_fall = ~sync_b[3] & sync_q[3];
    assign frame_start = bclk_rise & sync_b[4] & ~fs_last;

    // serial control port: header byte then data byte
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sc_cnt <= '0;
            sc_sh <= '0;
            sc_addr <= '0;
            sc_rd <= 1'b0;
        end
        else if (sync_b[1])
            sc_cnt <= '0;
        else if (cclk_rise)
        begin
            sc_sh <= {sc_sh[6:0], sync_b[2]};
            if (sc_cnt == HDR_LAST)
            begin
                sc_rd <= sc_sh[6];
                sc_addr <= {sc_sh[2:0], sync_b[2]};
            end
            if (sc_cnt != CNT_STOP)
                sc_cnt <= sc_cnt + 5'd1;
        end
    end

    assign host_wdata = {sc_sh[6:0], sync_b[2]};
    assign addr_ok = (sc_addr >= 4'(IDX_PCM_CFG)) && (sc_addr <= 4'(NUM_REGS));
    assign host_wr = cclk_rise & ~sync_b[1] & (sc_cnt == DATA_LAST) & ~sc_rd & addr_ok;

    // read value for the addressed register
    always_comb
    begin
        rd_val = '0;
        if (sc_addr == 4'(IDX_RX_DATA))
            rd_val = cfg_act[IDX_RX_DATA];
        else if (sc_addr == 4'(IDX_TX_DATA))
            rd_val = '0;
        else if (sc_addr == 4'(IDX_REMOTE))
            rd_val = {cfg_stage[IDX_REMOTE][7:5], key_flag, cfg_stage[IDX_REMOTE][3:0]};
        else if (addr_ok)
            rd_val = cfg_stage[sc_addr];
    end

    // read data leaves on falling control clock, msb first
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_out <= 1'b0;
            ctrl_oe <= 1'b0;
        end
        else if (sync_b[1])
            ctrl_oe <= 1'b0;
        else if (cclk_fall && sc_rd && sc_cnt >= DATA_FIRST && sc_cnt <= DATA_LAST)
        begin
            ctrl_oe <= 1'b1;
            ctrl_out <= rd_val[3'(DATA_LAST - sc_cnt)];
        end
    end

    // staged copies written by the host
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 1; i <= NUM_REGS; i++)
                cfg_stage[i] <= REG_RESET;
        end
        else if (host_wr)
            cfg_stage[sc_addr] <= host_wdata;
    end

    // commit at frame start, or at once while voice transfer is off
    assign commit = frame_start | ~cfg_act[IDX_PCM_CFG][VOICE_EN_BIT];

    // active settings; receive data also captures the incoming slot
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 1; i <= NUM_REGS; i++)
                cfg_act[i] <= REG_RESET;
            rx_pend <= 1'b0;
        end
        else
        begin
            if (commit)
            begin
                for (int i = 1; i <= NUM_REGS; i++)
                    if (i != IDX_RX_DATA)
                        cfg_act[i] <= cfg_stage[i];
            end
            if (commit && rx_pend)
                cfg_act[IDX_RX_DATA] <= cfg_stage[IDX_RX_DATA];
            else if (rx_done && !pcm_cfg[RX_OVR_BIT])
                cfg_act[IDX_RX_DATA] <= {rx_sh[6:0], sync_b[5]};
            if (host_wr && sc_addr == 4'(IDX_RX_DATA))
                rx_pend <= 1'b1;
            else if (commit)
                rx_pend <= 1'b0;
        end
    end

    // timing mode decode and slot position
    assign pcm_cfg = cfg_act[IDX_PCM_CFG];
    assign delayed = ~pcm_cfg[TM_HI_BIT];
    assign reverse = pcm_cfg[TM_HI_BIT] & pcm_cfg[TM_LO_BIT];
    assign pcm_active = pcm_cfg[VOICE_EN_BIT] & companded_mode;
    assign slot_start = pcm_cfg[BCHAN_BIT] ? SLOT_B2 : SLOT_B1;

    // next bit position: delayed timing starts one clock later
    always_comb
    begin
        next_pos = bit_pos;
        if (frame_start)
            next_pos = delayed ? POS_PRE : SLOT_B1;
        else if (bclk_rise && bit_pos != POS_END)
            next_pos = bit_pos + 6'd1;
    end

    assign cur_idx = bit_pos - slot_start;
    assign nxt_idx = next_pos - slot_start;
    assign launch = reverse ? bclk_fall : bclk_rise;
    assign sample = reverse ? bclk_rise : bclk_fall;
    assign launch_idx = reverse ? cur_idx : nxt_idx;
    assign rx_done = sample & pcm_active & (cur_idx == SLOT_LEN - 6'd1);

    // frame position tracking
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_pos <= POS_END;
            fs_last <= 1'b0;
        end
        else
        begin
            bit_pos <= next_pos;
            if (bclk_rise)
                fs_last <= sync_b[4];
        end
    end

    // transmit byte source chosen at frame start
    assign tone_byte = (tone_one | tone_two) ? TONE_HIGH_CODE : TONE_LOW_CODE;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            tx_byte <= '0;
        else if (frame_start)
        begin
            if (pcm_cfg[TX_OVR_BIT])
                tx_byte <= cfg_act[IDX_TX_DATA];
            else if (cfg_act[IDX_TONE][TONE_TX_BIT])
                tx_byte <= tone_byte;
            else
                tx_byte <= tx_path_data;
        end
    end

    // transmit pin drive inside the chosen slot only
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pcm_tx_out <= 1'b0;
            pcm_tx_oe <= 1'b0;
        end
        else if (!pcm_active)
            pcm_tx_oe <= 1'b0;
        else if (launch)
        begin
            pcm_tx_oe <= (launch_idx < SLOT_LEN);
            if (launch_idx < SLOT_LEN)
                pcm_tx_out <= tx_byte[3'd7 - launch_idx[2:0]];
        end
    end

    // receive shift and hand-off to the decoder path
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_sh <= '0;
            rx_path_data <= '0;
            rx_path_valid <= 1'b0;
        end
        else
        begin
            rx_path_valid <= rx_done;
            if (sample && pcm_active && cur_idx < SLOT_LEN)
                rx_sh <= {rx_sh[6:0], sync_b[5]};
            if (rx_done)
            begin
                if (pcm_cfg[RX_OVR_BIT])
                    rx_path_data <= cfg_act[IDX_RX_DATA];
                else
                    rx_path_data <= {rx_sh[6:0], sync_b[5]};
            end
        end
    end

    // analog control fields; driver bits passed as the host set them
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            latch_pin <= 1'b1;
            sidetone_on <= 1'b0;
            clock_source_pick <= 1'b0;
        end
        else
        begin
            latch_pin <= ~pcm_cfg[LATCH_BIT];
            clock_source_pick <= pcm_cfg[CLKSRC_BIT];
            sidetone_on <= cfg_act[IDX_PATH][SIDETONE_BIT] &&
                (cfg_act[IDX_PATH][MIC_A_BIT:MIC_B_BIT] != MIC_MUTE);
        end
    end

    assign mic_select_a = cfg_act[IDX_PATH][MIC_A_BIT];
    assign mic_select_b = cfg_act[IDX_PATH][MIC_B_BIT];
    assign earpiece_drive_on = cfg_act[IDX_PATH][EAR_ON_BIT];
    assign extra_amp_drive_on = cfg_act[IDX_PATH][EXTRA_ON_BIT];
    assign ring_gen_route = cfg_act[IDX_PATH][RING_ROUTE_BIT];
    assign rx_highpass_cut = cfg_act[IDX_PATH][HPF_BIT];
    assign rx_speech_route = cfg_act[IDX_PATH][SPEECH_BIT];
    assign tx_gain = cfg_act[IDX_TX_GAIN][7:4];
    assign sidetone_atten = cfg_act[IDX_TX_GAIN][3:0];
    assign ear_atten = cfg_act[IDX_RX_GAIN][7:4];
    assign extra_atten = cfg_act[IDX_RX_GAIN][3:0];
    assign ring_atten = cfg_act[IDX_TONE][7:4];
    assign low_tone_gen_on = cfg_act[IDX_TONE][TONE_F1_BIT];
    assign high_tone_gen_on = cfg_act[IDX_TONE][TONE_F2_BIT];
    assign waveform_pick = cfg_act[IDX_TONE][TONE_WAVE_BIT];
    assign gen_to_tx_path = cfg_act[IDX_TONE][TONE_TX_BIT];

    // 512 kHz tick for the tone accumulators
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            tick_cnt <= '0;
        else if (nco_tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 1'b1;
    end
    assign nco_tick = (tick_cnt == $bits(tick_cnt)'(NCO_DIV - 1));

    tone_nco u_tone_one (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(nco_tick),
        .enable(low_tone_gen_on),
        .step(cfg_act[IDX_FREQ_ONE]),
        .range(tone_range_t'(cfg_act[IDX_REMOTE][1:0])),
        .wave(tone_one)
    );

    tone_nco u_tone_two (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(nco_tick),
        .enable(high_tone_gen_on),
        .step(cfg_act[IDX_FREQ_TWO]),
        .range(tone_range_t'(cfg_act[IDX_REMOTE][1:0])),
        .wave(tone_two)
    );

    // remote key debounce: level must hold the full time to be taken
    assign deb_done = (sync_b[6] != key_stable) && (deb_cnt == DEB_W'(DEBOUNCE_CYCLES - 1));
    assign key_set = deb_done & ~sync_b[6] & cfg_act[IDX_REMOTE][REM_EN_BIT];

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            deb_cnt <= '0;
            key_stable <= 1'b1;
        end
        else if (sync_b[6] == key_stable)
            deb_cnt <= '0;
        else if (deb_done)
        begin
            key_stable <= sync_b[6];
            deb_cnt <= '0;
        end
        else
            deb_cnt <= deb_cnt + 1'b1;
    end

    // detect flag and key output; a new press beats a host clear
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            key_flag <= 1'b0;
            key_detect_out <= 1'b0;
        end
        else
        begin
            if (key_set)
                key_flag <= 1'b1;
            else if (host_wr && sc_addr == 4'(IDX_REMOTE) && !host_wdata[REM_FLAG_BIT])
                key_flag <= 1'b0;
            key_detect_out <= cfg_act[IDX_REMOTE][REM_INV_BIT] ^
                (cfg_act[IDX_REMOTE][REM_EN_BIT] & (cfg_act[IDX_REMOTE][REM_LATCH_BIT] ?
                key_flag : ~key_stable));
        end
    end

    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_voice_off;
        !pcm_cfg[VOICE_EN_BIT] |=> !pcm_tx_oe;
    endproperty
    a_voice_off: assert property (p_voice_off) else $error("tx driven while disabled");

    property p_latch_inv;
        $changed(pcm_cfg[LATCH_BIT]) |=> latch_pin == !$past(pcm_cfg[LATCH_BIT]);
    endproperty
    a_latch_inv: assert property (p_latch_inv) else $error("latch pin not inverse");

    property p_rx_override;
        rx_done && pcm_cfg[RX_OVR_BIT] |=> rx_path_valid && rx_path_data == $past(cfg_act[IDX_RX_DATA]);
    endproperty
    a_rx_override: assert property (p_rx_override) else $error("override byte not sent");

    property p_companded_only;
        pcm_tx_oe |-> $past(companded_mode);
    endproperty
    a_companded_only: assert property (p_companded_only) else $error("slot used in linear mode");

    property p_sidetone_off;
        sidetone_on |-> $past(cfg_act[IDX_PATH][MIC_A_BIT:MIC_B_BIT]) != MIC_MUTE;
    endproperty
    a_sidetone_off: assert property (p_sidetone_off) else $error("sidetone with tx muted");

    property p_hold_mid_frame;
        !commit |=> cfg_act[IDX_PATH] == $past(cfg_act[IDX_PATH]);
    endproperty
    a_hold_mid_frame: assert property (p_hold_mid_frame) else $error("setting moved mid frame");

    property p_key_disabled;
        !cfg_act[IDX_REMOTE][REM_EN_BIT] && !key_flag |=> !key_flag;
    endproperty
    a_key_disabled: assert property (p_key_disabled) else $error("flag set while disabled");

    property p_flag_set;
        key_set |=> key_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("detect flag lost");

    property p_msb_first;
        launch && pcm_active && launch_idx == 6'd0 |=> pcm_tx_out == $past(tx_byte[7]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first slot bit not msb");

    c_rx_word: cover property (rx_path_valid);
    c_tx_slot: cover property ($rose(pcm_tx_oe));
    c_key_flag: cover property ($rose(key_flag));
endmodule

/* dv/pcm_far_end.sv */
// far-end pcm model: bit clock, sync, receive bits, transmit capture
`timescale 1ns/1ps
module pcm_far_end
(
    input wire logic run,
    input wire logic [7:0] rx_byte,
    input wire logic pcm_tx_out,
    input wire logic pcm_tx_oe,
    output logic pcm_clk,
    output logic pcm_sync,
    output logic pcm_rx_in,
    output logic [7:0] tx_seen,
    output logic [4:0] oe_cnt
);
    // 24-bit frames while run is high; clock stands still between
    initial
    begin
        pcm_clk = 1'b0;
        pcm_sync = 1'b0;
        pcm_rx_in = 1'b0;
        tx_seen = 8'h00;
        oe_cnt = 5'h00;
        forever
        begin
            wait (run);
            for (int i = 0; i < 24; i++)
            begin
                pcm_sync = (i == 0);
                if (i >= 1 && i <= 8)
                    pcm_rx_in = rx_byte[8 - i];
                else
                    pcm_rx_in = ~pcm_rx_in; // no stale level outside the slot
                #10 pcm_clk = 1'b1;
                #70 pcm_clk = 1'b0;
                // transmit bits taken on falls while driven
                if (i == 0)
                begin
                    tx_seen = 8'h00;
                    oe_cnt = 5'h00;
                end
                else if (pcm_tx_oe === 1'b1)
                begin
                    tx_seen = {tx_seen[6:0], pcm_tx_out};
                    oe_cnt = oe_cnt + 5'h01;
                end
                #80;
            end
        end
    end
endmodule

/* dv/codec_audio_control_regs_tb.sv */
// self-checking bench for the codec control register block
`timescale 1ns/1ps
module codec_audio_control_regs_tb;
    import codec_ctrl_pkg::*;
    logic ref_clk, nrst, ctrl_clk, ctrl_sel_n, ctrl_in, ctrl_out, ctrl_oe, run;
    logic pcm_clk, pcm_sync, pcm_rx_in, pcm_tx_out, pcm_tx_oe, companded_mode;
    logic rx_path_valid, remote_key_n, key_detect_out, latch_pin, clock_source_pick;
    logic mic_select_a, mic_select_b, sidetone_on, earpiece_drive_on, extra_amp_drive_on;
    logic ring_gen_route, rx_highpass_cut, rx_speech_route, low_tone_gen_on;
    logic high_tone_gen_on, waveform_pick, gen_to_tx_path, tone_one, tone_two;
    logic [3:0] sidetone_atten, tx_gain, ear_atten, extra_atten, ring_atten;
    logic [7:0] tx_path_data, rx_path_data, rx_byte, tx_seen, rx_got, v;
    logic [4:0] oe_cnt;
    int mismatches = 0;
    int checked = 0;
    // index, written byte, expected readback
    logic [7:0] rows [7][3] = '{'{8'h05, 8'hA3, 8'hA3}, '{8'h06, 8'h5C, 8'h5C},
        '{8'h04, 8'h95, 8'h95}, '{8'h08, 8'h20, 8'h20}, '{8'h09, 8'h7F, 8'h7F},
        '{8'h03, 8'h55, 8'h00}, '{8'h0B, 8'h66, 8'h00}};
    codec_audio_control_regs #(.DEBOUNCE_CYCLES(20)) DUT (.*);
    pcm_far_end far (.*);
    // system clock
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // last byte handed to the decoder
    always @(posedge ref_clk)
        if (rx_path_valid === 1'b1)
            rx_got <= rx_path_data;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // one 16-bit control transfer, msb first, read bits taken on rises
    task automatic xfer(input logic [7:0] h, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] w;
        w = {h, d};
        @(posedge ref_clk);
        #1 ctrl_sel_n = 1'b0;
        for (int k = 15; k >= 0; k--)
        begin
            ctrl_in = w[k];
            #104 ctrl_clk = 1'b1;
            q = {q[6:0], ctrl_out};
            #104 ctrl_clk = 1'b0;
        end
        #104 ctrl_sel_n = 1'b1;
        #104;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        xfer(i, d, v);
    endtask
    task automatic rd(input logic [7:0] i);
        xfer(8'h80 | i, 8'h00, v);
    endtask
    // two frames with a given receive byte
    task automatic frames(input logic [7:0] b);
        rx_byte = b;
        run = 1'b1;
        #4000 run = 1'b0;
        #4000;
    endtask
    task automatic press;
        @(posedge ref_clk);
        #1 remote_key_n = 1'b0;
        #400 remote_key_n = 1'b1;
        #200;
    endtask
    task automatic stop_test;
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #400000;
        mismatches++;
        stop_test;
    end
    initial
    begin
        {nrst, ctrl_clk, ctrl_in, run, rx_byte, rx_got} = '0;
        {ctrl_sel_n, companded_mode, remote_key_n} = 3'b111;
        tx_path_data = 8'h96;
        repeat (2) @(posedge ref_clk);
        #1 nrst = 1'b1;
        #100;
        chk("latch", 8'h01, 8'(latch_pin));
        rd(1);
        chk("cfg", 8'h00, v);
        foreach (rows[i])
        begin
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0]);
            chk("readback", rows[i][2], v);
        end
        chk("txgain", 8'h0A, 8'(tx_gain));
        chk("ear", 8'h05, 8'(ear_atten));
        chk("extra", 8'h0C, 8'(extra_atten));
        wr(4, 8'h24);
        chk("sidetone", 8'h00, 8'(sidetone_on));
        wr(3, 8'hA5);
        wr(1, 8'h2D);
        chk("latch", 8'h00, 8'(latch_pin));
        chk("clksrc", 8'h01, 8'(clock_source_pick));
        frames(8'h3C);
        chk("txbyte", 8'hA5, tx_seen);
        chk("oecnt", 8'h08, 8'(oe_cnt));
        chk("rxbyte", 8'h3C, rx_got);
        rd(2);
        chk("rxreg", 8'h3C, v);
        wr(2, 8'h5A);
        wr(1, 8'h14);
        chk("latch", 8'h00, 8'(latch_pin));
        frames(8'hC3);
        chk("latch", 8'h01, 8'(latch_pin));
        chk("rxbyte", 8'h5A, rx_got);
        wr(7, 8'h01);
        frames(8'h00);
        chk("tone", TONE_LOW_CODE, tx_seen);
        wr(7, 8'h00);
        frames(8'h00);
        chk("encoder", 8'h96, tx_seen);
        @(posedge ref_clk);
        #1 companded_mode = 1'b0;
        frames(8'h00);
        chk("oecnt", 8'h00, 8'(oe_cnt));
        @(posedge ref_clk);
        #1 companded_mode = 1'b1;
        wr(1, 8'h00);
        frames(8'h00);
        chk("oecnt", 8'h00, 8'(oe_cnt));
        press;
        chk("key", 8'h00, 8'(key_detect_out));
        wr(10, 8'hC0);
        press;
        chk("key", 8'h01, 8'(key_detect_out));
        rd(10);
        chk("flag", 8'hD0, v);
        wr(10, 8'hC0);
        rd(10);
        chk("flag", 8'hC0, v);
        stop_test;
    end
endmodule
